/* File: rtl/rrs_pkg.sv */
// package: opcodes, field positions, widths and reset values for the decode and core blocks
package rrs_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam int OP_W = 14;
	localparam int ADDR_W = 7;
	localparam logic [13:0] OPC_RETURN = 14'h0008;
	localparam logic [13:0] OPC_SLEEP = 14'h0063;
	localparam logic [5:0] OPC_ROT_LEFT = 6'h0D;
	localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;
	localparam int OPC_PREFIX_HI = 13;
	localparam int OPC_PREFIX_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;

	typedef enum {RRS_OP_NOP, RRS_OP_RETURN, RRS_OP_ROT_LEFT, RRS_OP_ROT_RIGHT,
		RRS_OP_SLEEP} rrs_op_t;

	// decoded instruction fields
	typedef struct packed {
		logic dest_file;
		logic [6:0] addr;
	} rrs_fields_t;

	// write request toward the file register array
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} rrs_file_wr_t;
endpackage

/* File: rtl/rrs_decode.sv */
// opcode decoder for return, rotate and sleep
`timescale 1ns/100ps
module rrs_decode
	import rrs_pkg::*;
(
	input wire logic [13:0] instr_in,
	output rrs_op_t op_out,
	output rrs_fields_t fields_out
);
	always_comb
	begin
		op_out = RRS_OP_NOP;
		if (instr_in == OPC_RETURN)
			op_out = RRS_OP_RETURN;
		else if (instr_in == OPC_SLEEP)
			op_out = RRS_OP_SLEEP;
		else if (instr_in[OPC_PREFIX_HI:OPC_PREFIX_LO] == OPC_ROT_LEFT)
			op_out = RRS_OP_ROT_LEFT;
		else if (instr_in[OPC_PREFIX_HI:OPC_PREFIX_LO] == OPC_ROT_RIGHT)
			op_out = RRS_OP_ROT_RIGHT;
	end

	assign fields_out.dest_file = instr_in[DEST_BIT];
	assign fields_out.addr = instr_in[ADDR_HI:ADDR_LO];
endmodule

/* File: rtl/rrs_core.sv */
// execute logic for return, rotate through carry and sleep
`timescale 1ns/100ps
module rrs_core
	import rrs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [13:0] instr_in,
	input wire logic instr_valid_in,
	input wire logic [7:0] file_rd_data_in,
	input wire logic [12:0] stack_top_value_in,
	input wire logic wake_in,
	output logic [1:0] phase_out,
	output logic [6:0] file_rd_addr_out,
	output rrs_file_wr_t file_wr_out,
	output logic [7:0] w_reg_out,
	output logic carry_out,
	output logic [12:0] pc_out,
	output logic pc_load_out,
	output logic stack_pop_out,
	output logic flush_out,
	output logic power_down_flag_n_out,
	output logic time_out_flag_n_out,
	output logic [7:0] watchdog_counter_out,
	output logic [7:0] prescaler_out,
	output logic wdt_clear_out,
	output logic osc_run_out,
	output logic sleep_out
);
	typedef enum {RRS_RUN, RRS_FLUSH, RRS_SLEEP} rrs_state_t;

	rrs_state_t state;
	rrs_op_t op;
	rrs_op_t dec_op;
	rrs_fields_t dec_fields;
	logic [13:0] ir;
	logic [1:0] phase;
	logic [7:0] rot_result;
	logic next_carry;
	logic exec_q4;

	rrs_decode u_decode
	(
		.instr_in(ir),
		.op_out(dec_op),
		.fields_out(dec_fields)
	);

	////////////////////////////////////////////////////////////////////////////
	// four-phase sequencer, halted in sleep
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			phase <= PH_Q1;
		else if (state != RRS_SLEEP)
			phase <= phase + 2'h1;
	end

	// word latched on every Q4 edge; the word fetched during a return is masked in flush,
	// the word from the restored pc is taken at the end of the flush cycle
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			ir <= 14'h0000;
		else if (phase == PH_Q4 && instr_valid_in)
			ir <= instr_in;
		else if (phase == PH_Q4)
			ir <= 14'h0000;
	end

	always_comb
	begin
		op = (state == RRS_RUN) ? dec_op : RRS_OP_NOP;
	end

	assign exec_q4 = (phase == PH_Q4);

	////////////////////////////////////////////////////////////////////////////
	// control state
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state <= RRS_RUN;
		else
		begin
			unique case (state)
				RRS_RUN:
				begin
					if (exec_q4 && op == RRS_OP_RETURN)
						state <= RRS_FLUSH;
					else if (exec_q4 && op == RRS_OP_SLEEP)
						state <= RRS_SLEEP;
				end
				RRS_FLUSH:
				begin
					if (exec_q4)
						state <= RRS_RUN;
				end
				RRS_SLEEP:
				begin
					if (wake_in)
						state <= RRS_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// rotate datapath
	always_comb
	begin
		rot_result = file_rd_data_in;
		next_carry = carry_out;
		if (op == RRS_OP_ROT_LEFT)
		begin
			rot_result = {file_rd_data_in[6:0], carry_out};
			next_carry = file_rd_data_in[7];
		end
		else if (op == RRS_OP_ROT_RIGHT)
		begin
			rot_result = {carry_out, file_rd_data_in[7:1]};
			next_carry = file_rd_data_in[0];
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			carry_out <= 1'b0;
			w_reg_out <= W_RESET;
			file_wr_out <= '0;
			file_rd_addr_out <= 7'h00;
		end
		else
		begin
			file_wr_out.en <= 1'b0;
			if (phase == PH_Q1)
				file_rd_addr_out <= dec_fields.addr;
			if (exec_q4 && (op == RRS_OP_ROT_LEFT || op == RRS_OP_ROT_RIGHT))
			begin
				carry_out <= next_carry;
				if (dec_fields.dest_file)
				begin
					file_wr_out.en <= 1'b1;
					file_wr_out.addr <= dec_fields.addr;
					file_wr_out.data <= rot_result;
				end
				else
					w_reg_out <= rot_result;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// return: pop and load program counter
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pc_out <= PC_RESET;
			pc_load_out <= 1'b0;
			stack_pop_out <= 1'b0;
			flush_out <= 1'b0;
		end
		else
		begin
			pc_load_out <= 1'b0;
			stack_pop_out <= 1'b0;
			if (exec_q4 && op == RRS_OP_RETURN)
			begin
				stack_pop_out <= 1'b1;
				pc_load_out <= 1'b1;
				pc_out <= stack_top_value_in;
			end
			if (exec_q4)
				flush_out <= (op == RRS_OP_RETURN);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep: status flags, watchdog clear, oscillator stop
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			power_down_flag_n_out <= 1'b1;
			time_out_flag_n_out <= 1'b1;
			watchdog_counter_out <= WDT_CLEAR;
			prescaler_out <= PRESCALE_CLEAR;
			wdt_clear_out <= 1'b0;
			osc_run_out <= 1'b1;
			sleep_out <= 1'b0;
		end
		else
		begin
			wdt_clear_out <= 1'b0;
			if (exec_q4 && op == RRS_OP_SLEEP)
			begin
				power_down_flag_n_out <= 1'b0;
				time_out_flag_n_out <= 1'b1;
				watchdog_counter_out <= WDT_CLEAR;
				prescaler_out <= PRESCALE_CLEAR;
				wdt_clear_out <= 1'b1;
				osc_run_out <= 1'b0;
				sleep_out <= 1'b1;
			end
			else if (state == RRS_SLEEP && wake_in)
			begin
				osc_run_out <= 1'b1;
				sleep_out <= 1'b0;
			end
		end
	end

	assign phase_out = phase;
endmodule

/* File: tb/rrs_core_chk.sv */
// checker: timing of return, rotate and sleep at the core ports
`timescale 1ns/100ps
module rrs_core_chk
	import rrs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [1:0] phase_out,
	input wire rrs_file_wr_t file_wr_out,
	input wire logic [7:0] w_reg_out,
	input wire logic carry_out,
	input wire logic pc_load_out,
	input wire logic stack_pop_out,
	input wire logic flush_out,
	input wire logic power_down_flag_n_out,
	input wire logic time_out_flag_n_out,
	input wire logic [7:0] watchdog_counter_out,
	input wire logic [7:0] prescaler_out,
	input wire logic wdt_clear_out,
	input wire logic osc_run_out,
	input wire logic sleep_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	a_pop_loads_pc: assert property (stack_pop_out |-> pc_load_out)
		else $error("pop without pc load");
	a_pop_keeps_carry: assert property (stack_pop_out |-> $stable(carry_out))
		else $error("carry changed on return");
	a_pop_in_q4: assert property (stack_pop_out |-> $past(phase_out) == PH_Q4)
		else $error("pop outside last phase");
	a_flush_one_cycle: assert property (stack_pop_out |-> flush_out [*4] ##1 !flush_out)
		else $error("flush not one cycle long");
	a_flush_no_write: assert property (flush_out |-> !file_wr_out.en)
		else $error("write during flush");
	a_write_keeps_w: assert property (file_wr_out.en |-> $stable(w_reg_out))
		else $error("w changed on file write");
	a_write_pulse: assert property (file_wr_out.en |=> !file_wr_out.en)
		else $error("write pulse too long");
	a_sleep_status: assert property ($rose(sleep_out) |-> !power_down_flag_n_out
		&& time_out_flag_n_out && wdt_clear_out)
		else $error("status wrong at sleep");
	a_sleep_wdt_zero: assert property ($rose(sleep_out) |->
		watchdog_counter_out == WDT_CLEAR && prescaler_out == PRESCALE_CLEAR)
		else $error("watchdog not cleared");
	a_sleep_osc_off: assert property (sleep_out |-> !osc_run_out)
		else $error("oscillator runs in sleep");
	a_sleep_phase_hold: assert property (sleep_out && $past(sleep_out) |-> $stable(phase_out))
		else $error("phase moved in sleep");
endmodule
bind rrs_core rrs_core_chk chk (.core_clk_in, .nrst_in, .phase_out, .file_wr_out, .w_reg_out,
	.carry_out, .pc_load_out, .stack_pop_out, .flush_out, .power_down_flag_n_out,
	.time_out_flag_n_out, .watchdog_counter_out, .prescaler_out, .wdt_clear_out,
	.osc_run_out, .sleep_out);

/* File: tb/return_rotate_sleep_ops_tb.sv */
// testbench: random rotates and returns, then sleep and wake
`timescale 1ns/100ps
module return_rotate_sleep_ops_tb
	import rrs_pkg::*;
;
	logic core_clk_in = 0, nrst_in = 0, instr_valid_in = 0, wake_in = 0;
	logic [13:0] instr_in = 14'h0000;
	logic [7:0] file_rd_data_in = 8'h00;
	logic [12:0] stack_top_value_in = 13'h0000;
	logic [1:0] phase_out;
	logic [6:0] file_rd_addr_out;
	rrs_file_wr_t file_wr_out;
	logic [7:0] w_reg_out, watchdog_counter_out, prescaler_out, w0;
	logic [12:0] pc_out;
	logic carry_out, pc_load_out, stack_pop_out, flush_out, power_down_flag_n_out;
	logic time_out_flag_n_out, wdt_clear_out, osc_run_out, sleep_out, c0;
	logic [8:0] e;
	logic [31:0] r;
	int failures = 0, total_checks = 0;
	integer seed = 32'h5EF766CB;
	rrs_core dut (.core_clk_in, .nrst_in, .instr_in, .instr_valid_in, .file_rd_data_in,
		.stack_top_value_in, .wake_in, .phase_out, .file_rd_addr_out, .file_wr_out, .w_reg_out,
		.carry_out, .pc_out, .pc_load_out, .stack_pop_out, .flush_out, .power_down_flag_n_out,
		.time_out_flag_n_out, .watchdog_counter_out, .prescaler_out, .wdt_clear_out,
		.osc_run_out, .sleep_out);
	function automatic logic [8:0] rot_exp(logic left, logic c, logic [7:0] d);
		return left ? {d, c} : {d[0], c, d[7:1]};
	endfunction
	task chk(string n, logic [15:0] ex, logic [15:0] s);
		total_checks++;
		if (ex !== s)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, ex, s);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// capture at a Q4 edge, then wait out the execute cycle
	task go(logic [13:0] w);
		while (phase_out !== PH_Q4) @(posedge core_clk_in) #1;
		instr_in = w;
		instr_valid_in = 1'b1;
		@(posedge core_clk_in) #1;
		instr_in = 14'h0D00;
		instr_valid_in = (w === OPC_RETURN);
		repeat (4) @(posedge core_clk_in);
		#1;
	endtask
	initial forever #2 core_clk_in = ~core_clk_in;
	initial
	begin
		#20000;
		failures++;
		$display("Error watchdog expected done seen timeout");
		tally_and_finish;
	end
	initial
	begin
		repeat (5) @(posedge core_clk_in);
		#1 nrst_in = 1'b1;
		chk("flags_rst", 2'h3, {power_down_flag_n_out, time_out_flag_n_out});
		for (int i = 0; i < 30; i++)
		begin
			r = $random(seed);
			if (i < 2)
				r[23:8] = i ? 16'h0000 : 16'hFFFF;
			c0 = carry_out;
			w0 = w_reg_out;
			file_rd_data_in = r[23:16];
			stack_top_value_in = r[28:16];
			if (r[1:0] == 2'h2)
			begin
				go(OPC_RETURN);
				chk("pc", r[28:16], pc_out);
				chk("pop", 3'h7, {stack_pop_out, pc_load_out, flush_out});
				instr_valid_in = 1'b0;
				repeat (4) @(posedge core_clk_in);
				#1 chk("flushed", {c0, w0}, {carry_out, w_reg_out});
			end
			else
			begin
				e = rot_exp(!r[0], c0, r[23:16]);
				go({r[0] ? OPC_ROT_RIGHT : OPC_ROT_LEFT, r[8], r[15:9]});
				chk("carry", e[8], carry_out);
				chk("w", r[8] ? w0 : e[7:0], w_reg_out);
				chk("wr_en", r[8], file_wr_out.en);
				if (r[8]) chk("wr", {1'b1, r[15:9], e[7:0]}, file_wr_out);
				chk("rd_addr", r[15:9], file_rd_addr_out);
			end
		end
		w0 = w_reg_out;
		go(OPC_SLEEP);
		chk("flags", 2'h1, {power_down_flag_n_out, time_out_flag_n_out});
		chk("wdt", 16'h0000, {watchdog_counter_out, prescaler_out});
		chk("halt", 3'h5, {wdt_clear_out, osc_run_out, sleep_out});
		e[1:0] = phase_out;
		instr_valid_in = 1'b1;
		repeat (8) @(posedge core_clk_in);
		#1 chk("frozen", {e[1:0], w0}, {phase_out, w_reg_out});
		wake_in = 1'b1;
		@(posedge core_clk_in) #1 wake_in = 1'b0;
		instr_valid_in = 1'b0;
		chk("woken", 2'h2, {osc_run_out, sleep_out});
		tally_and_finish;
	end
endmodule
